/* core/ccdj_defs.vh */
// constants for the clear/complement/decrement/jump execution block
`ifndef CCDJ_DEFS_VH
`define CCDJ_DEFS_VH
`define CCDJ_OP_NONE       3'h0
`define CCDJ_OP_COMPLEMENT 3'h1
`define CCDJ_OP_CLEAR_FILE 3'h2
`define CCDJ_OP_CLEAR_ACC  3'h3
`define CCDJ_OP_DECREMENT  3'h4
`define CCDJ_OP_DEC_SKIP   3'h5
`define CCDJ_OP_JUMP       3'h6
`define CCDJ_DEST_ACC      1'h0
`define CCDJ_DEST_FILE     1'h1
`define CCDJ_ZERO_BYTE     8'h00
`define CCDJ_COUNTER_RESET 15'h0000
`define CCDJ_ACC_RESET     8'h00
`define CCDJ_FLAG_RESET    1'h0
`define CCDJ_ADDR_RESET    7'h00
`define CCDJ_LATCH_HI      6
`define CCDJ_LATCH_LO      3
`endif

/* core/ccdj_alu.v */
// result arithmetic for complement, clear and decrement
`timescale 1ns/100ps
`include "ccdj_defs.vh"
module ccdj_alu (
  // operation and operand
  input  wire [2:0] op,
  input  wire [7:0] operand,
  // result
  output reg  [7:0] result,
  output wire       result_zero
);
  always @* begin
    case (op)
      `CCDJ_OP_COMPLEMENT: result = ~operand;
      `CCDJ_OP_DECREMENT,
      `CCDJ_OP_DEC_SKIP:   result = operand - 8'h01;
      default:        result = `CCDJ_ZERO_BYTE;
    endcase
  end
  assign result_zero = (result == `CCDJ_ZERO_BYTE);
endmodule // ccdj_alu

/* core/ccdj_exec.v */
// execution of clear, complement, decrement, skip and absolute jump
`timescale 1ns/100ps
`include "ccdj_defs.vh"
module ccdj_exec (
  // clock and reset
  input  wire        clock,
  input  wire        reset,
  // decoded instruction
  input  wire        issue,
  input  wire [2:0]  op,
  input  wire        dest,
  input  wire [6:0]  file_addr,
  input  wire [10:0] jump_target,
  // operand and latch
  input  wire [7:0]  file_data,
  input  wire [7:0]  upper_address_latch,
  // results
  output reg  [7:0]  acc_r,
  output reg         zero_flag_r,
  output reg         file_we_r,
  output reg  [6:0]  file_waddr_r,
  output reg  [7:0]  file_wdata_r,
  output reg  [14:0] program_counter_r,
  output reg         jump_load_r,
  output reg         flush_r,
  output reg         busy_r
);
  // state codes, one-hot
  localparam ST_RUN   = 2'h1;
  localparam ST_FLUSH = 2'h2;

  // sequencer and next values
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [7:0]  acc_nxt;
  reg         zero_flag_nxt;
  reg         file_we_nxt;
  reg  [6:0]  file_waddr_nxt;
  reg  [7:0]  file_wdata_nxt;
  reg  [14:0] program_counter_nxt;
  reg         jump_load_nxt;
  reg         flush_nxt;
  reg         busy_nxt;

  // arithmetic and decode
  wire [7:0]  result;
  wire        result_zero;
  wire        go;
  wire        jump;
  wire        skip;

  // single operation code match
  function is_op(input [2:0] code, input [2:0] want);
    is_op = (code == want);
  endfunction

  // operations writing the arithmetic result
  function writes_result(input [2:0] code);
    writes_result = is_op(code, `CCDJ_OP_COMPLEMENT) |
                    is_op(code, `CCDJ_OP_DECREMENT) |
                    is_op(code, `CCDJ_OP_DEC_SKIP);
  endfunction

  // operations deriving the zero flag from the result
  function updates_zero(input [2:0] code);
    updates_zero = is_op(code, `CCDJ_OP_COMPLEMENT) |
                   is_op(code, `CCDJ_OP_DECREMENT);
  endfunction

  // operations setting the zero flag outright
  function forces_zero(input [2:0] code);
    forces_zero = is_op(code, `CCDJ_OP_CLEAR_FILE) |
                  is_op(code, `CCDJ_OP_CLEAR_ACC);
  endfunction

  // result lands in the file register
  function targets_file(input [2:0] code, input dest_bit);
    targets_file = is_op(code, `CCDJ_OP_CLEAR_FILE) |
                   (writes_result(code) &
                    (dest_bit == `CCDJ_DEST_FILE));
  endfunction

  // result lands in the accumulator
  function targets_acc(input [2:0] code, input dest_bit);
    targets_acc = writes_result(code) & (dest_bit == `CCDJ_DEST_ACC);
  endfunction

  // full jump address from latch and operand
  function [14:0] jump_address(input [7:0] latch, input [10:0] target);
    jump_address = {latch[`CCDJ_LATCH_HI:`CCDJ_LATCH_LO], target};
  endfunction

  ccdj_alu u_alu (
    .op          (op),
    .operand     (file_data),
    .result      (result),
    .result_zero (result_zero)
  );

  // accepted only outside the discard slot
  assign go   = issue & (state_r == ST_RUN);
  assign jump = go & is_op(op, `CCDJ_OP_JUMP);
  assign skip = jump |
                (go & is_op(op, `CCDJ_OP_DEC_SKIP) & result_zero);

  // discard slot sequencing
  always @* begin
    case (state_r)
      ST_RUN:   state_nxt = skip ? ST_FLUSH : ST_RUN;
      ST_FLUSH: state_nxt = ST_RUN;
      default:  state_nxt = ST_RUN;
    endcase
  end

  // accumulator next value
  always @* begin
    acc_nxt = acc_r;
    if (go & is_op(op, `CCDJ_OP_CLEAR_ACC))
      acc_nxt = `CCDJ_ZERO_BYTE;
    else if (go & targets_acc(op, dest))
      acc_nxt = result;
  end

  // zero flag next value, held by skip and jump
  always @* begin
    zero_flag_nxt = zero_flag_r;
    if (go & forces_zero(op))
      zero_flag_nxt = 1'h1;
    else if (go & updates_zero(op))
      zero_flag_nxt = result_zero;
  end

  // file write port next values
  always @* begin
    file_we_nxt    = go & targets_file(op, dest);
    file_waddr_nxt = file_waddr_r;
    file_wdata_nxt = file_wdata_r;
    if (file_we_nxt) begin
      file_waddr_nxt = file_addr;
      file_wdata_nxt = result;
    end
  end

  // program counter next value
  always @* begin
    program_counter_nxt = program_counter_r;
    if (jump)
      program_counter_nxt = jump_address(upper_address_latch,
                                         jump_target);
  end

  // sequencing pulse next values
  always @* begin
    jump_load_nxt = jump;
    flush_nxt     = skip;
    busy_nxt      = (state_nxt == ST_FLUSH);
  end

  // sequencer register
  always @(posedge clock) begin
    if (reset)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // accumulator register
  always @(posedge clock) begin
    if (reset)
      acc_r <= `CCDJ_ACC_RESET;
    else
      acc_r <= acc_nxt;
  end

  // zero flag register
  always @(posedge clock) begin
    if (reset)
      zero_flag_r <= `CCDJ_FLAG_RESET;
    else
      zero_flag_r <= zero_flag_nxt;
  end

  // file write strobe register
  always @(posedge clock) begin
    if (reset)
      file_we_r <= `CCDJ_FLAG_RESET;
    else
      file_we_r <= file_we_nxt;
  end

  // file write address register
  always @(posedge clock) begin
    if (reset)
      file_waddr_r <= `CCDJ_ADDR_RESET;
    else
      file_waddr_r <= file_waddr_nxt;
  end

  // file write data register
  always @(posedge clock) begin
    if (reset)
      file_wdata_r <= `CCDJ_ZERO_BYTE;
    else
      file_wdata_r <= file_wdata_nxt;
  end

  // program counter register
  always @(posedge clock) begin
    if (reset)
      program_counter_r <= `CCDJ_COUNTER_RESET;
    else
      program_counter_r <= program_counter_nxt;
  end

  // jump load pulse register
  always @(posedge clock) begin
    if (reset)
      jump_load_r <= `CCDJ_FLAG_RESET;
    else
      jump_load_r <= jump_load_nxt;
  end

  // flush pulse register
  always @(posedge clock) begin
    if (reset)
      flush_r <= `CCDJ_FLAG_RESET;
    else
      flush_r <= flush_nxt;
  end

  // discard slot indicator register
  always @(posedge clock) begin
    if (reset)
      busy_r <= `CCDJ_FLAG_RESET;
    else
      busy_r <= busy_nxt;
  end
endmodule // ccdj_exec

/* test/ccdj_exec_chk.sv */
// assertion checker for the execution block
`timescale 1ns/100ps
module ccdj_exec_chk (
  // observed ports
  input logic        clock, reset, issue, dest, zero_flag_r,
  input logic        file_we_r, jump_load_r, flush_r, busy_r,
  input logic [2:0]  op,
  input logic [7:0]  file_data, upper_address_latch, acc_r, file_wdata_r,
  input logic [10:0] jump_target,
  input logic [14:0] program_counter_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire t = issue && !busy_r;
  property p_cm; t && op == 3'h1 && dest |=>
    file_we_r && file_wdata_r == ~$past(file_data); endproperty
  property p_cf; t && op == 3'h2 |=>
    file_we_r && file_wdata_r == 8'h00 && zero_flag_r; endproperty
  property p_cw; t && op == 3'h3 |=> acc_r == 8'h00 && zero_flag_r;
  endproperty
  property p_dc; t && op == 3'h4 && !dest |=> acc_r ==
    $past(file_data) - 8'h01 && zero_flag_r == ($past(file_data) == 8'h01);
  endproperty
  property p_sk; t && op == 3'h5 && file_data == 8'h01 |=>
    flush_r && busy_r && $stable(zero_flag_r); endproperty
  property p_ns; t && op == 3'h5 && file_data != 8'h01 |=>
    !flush_r && !busy_r; endproperty
  property p_jp; t && op == 3'h6 |=> jump_load_r && program_counter_r ==
    {$past(upper_address_latch[6:3]), $past(jump_target)}; endproperty
  property p_jf; t && op == 3'h6 |=> flush_r && busy_r ##1 !busy_r;
  endproperty
  property p_rf; issue && busy_r |=> !file_we_r && !flush_r &&
    !jump_load_r && $stable(acc_r) && $stable(zero_flag_r); endproperty
  property p_jz; t && op == 3'h6 |=> $stable(zero_flag_r); endproperty
  a_cm: assert property (p_cm) else $error("complement wrong");
  a_cf: assert property (p_cf) else $error("clear file wrong");
  a_cw: assert property (p_cw) else $error("clear acc wrong");
  a_dc: assert property (p_dc) else $error("decrement wrong");
  a_sk: assert property (p_sk) else $error("skip wrong");
  a_ns: assert property (p_ns) else $error("no skip wrong");
  a_jp: assert property (p_jp) else $error("jump target wrong");
  a_jf: assert property (p_jf) else $error("jump slot wrong");
  a_rf: assert property (p_rf) else $error("refused issue acted");
  a_jz: assert property (p_jz) else $error("jump touched flag");
  c_rf: cover property (issue && busy_r);
  c_sk: cover property (t && op == 3'h5 && file_data == 8'h01);
  c_jp: cover property (t && op == 3'h6);
  c_cm: cover property (t && op == 3'h1);
endmodule // ccdj_exec_chk
bind ccdj_exec ccdj_exec_chk u_chk (.*);

/* test/clear_complement_decrement_jump_exec_test.sv */
// self-checking bench for the execution block
`timescale 1ns/100ps
module clear_complement_decrement_jump_exec_test;
  logic clock = 0, reset = 1, issue = 0, dest = 0, z = 0, we, fl;
  logic [2:0] op = 0, o;
  logic [6:0] fa = 0, file_waddr_r;
  logic [7:0] fd = 0, lat = 0, acc = 0, r, d, acc_r, file_wdata_r;
  logic [10:0] tg = 0;
  logic [14:0] prog = 0, program_counter_r;
  logic zero_flag_r, file_we_r, jump_load_r, flush_r, busy_r;
  int failures = 0, checked = 0;
  always #5 clock = ~clock;
  ccdj_exec i_dut (.clock, .reset, .issue, .op, .dest, .file_addr(fa),
    .jump_target(tg), .file_data(fd), .upper_address_latch(lat), .acc_r,
    .zero_flag_r, .file_we_r, .file_waddr_r, .file_wdata_r,
    .program_counter_r, .jump_load_r, .flush_r, .busy_r);
  function logic [7:0] res(input logic [2:0] o, input logic [7:0] d);
    res = o == 3'h1 ? ~d : (o == 3'h2 || o == 3'h3) ? 8'h00 : d - 8'h01;
  endfunction
  task cmp(input logic [14:0] g, e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(97));
    repeat (8) @(posedge clock);
    reset <= 0;
    for (int k = 0; k < 400; k++) begin
      @(posedge clock);
      if (k == 200) begin
        reset <= 1;
        repeat (2) @(posedge clock);
        reset <= 0;
        acc = 8'h00;
        z = 1'b0;
        prog = 15'h0000;
        @(posedge clock);
        #1 cmp(program_counter_r, prog);
        cmp(15'(acc_r), 15'(acc));
        cmp(15'(zero_flag_r), 15'(z));
        cmp({file_we_r, flush_r, jump_load_r, busy_r}, 15'h0000);
        @(posedge clock);
      end
      o = 3'($urandom % 7);
      d = k % 3 == 0 ? 8'h01 : k % 3 == 1 ? 8'h00 : 8'($urandom);
      r = res(o, d);
      fl = o == 3'h6 || o == 3'h5 && r == 8'h00;
      issue <= 1;
      op <= o;
      fd <= d;
      dest <= 1'($urandom);
      fa <= 7'($urandom);
      tg <= 11'($urandom);
      lat <= 8'($urandom);
      @(posedge clock);
      issue <= fl;
      fd <= ~d;
      #1 we = o == 3'h2 || dest && o inside {3'h1, 3'h4, 3'h5};
      if (o inside {3'h1, 3'h3, 3'h4, 3'h5} && !we) acc = r;
      if (o inside {3'h1, 3'h2, 3'h3, 3'h4}) z = r == 8'h00;
      if (o == 3'h6) prog = {lat[6:3], tg};
      cmp(15'(acc_r), 15'(acc));
      cmp(15'(zero_flag_r), 15'(z));
      cmp(program_counter_r, prog);
      cmp({file_we_r, flush_r, jump_load_r, busy_r},
          {we, fl, o == 3'h6, fl});
      if (we) cmp({file_waddr_r, file_wdata_r}, {fa, r});
      @(posedge clock);
      issue <= 0;
      #1 cmp(15'(acc_r), 15'(acc));
      cmp(15'(zero_flag_r), 15'(z));
      cmp(program_counter_r, prog);
      cmp({file_we_r, flush_r, jump_load_r, busy_r}, 15'h0000);
    end
    tally_and_finish();
  end
endmodule // clear_complement_decrement_jump_exec_test
